// ### design/nine_bit_cfg_pkg.sv
// constants, field positions and carrier types for the serial port configuration block
package nine_bit_cfg_pkg;
  // ----------------------------------------------------------------
  // register indices
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_ACTIVATE = 8'h30;
  localparam logic [7:0] ADDR_BASE_HI = 8'h60;
  localparam logic [7:0] ADDR_BASE_LO = 8'h61;
  localparam logic [7:0] ADDR_IRQ_SEL = 8'h70;
  localparam logic [7:0] ADDR_OPTIONS = 8'hf0;
  localparam logic [7:0] ADDR_NB_CFG = 8'hf2;
  localparam logic [7:0] ADDR_SLAVE = 8'hf3;
  localparam logic [7:0] ADDR_MASK = 8'hf4;
  localparam logic [7:0] ADDR_BCAST = 8'hf5;
  localparam logic [7:0] ADDR_NB_IRQ_CTL = 8'hf6;
  localparam logic [7:0] ADDR_NB_IRQ_STS = 8'hf7;
  // ----------------------------------------------------------------
  // reset values and writable masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_ACTIVATE = 8'h01;
  localparam logic [7:0] RST_BASE_HI = 8'h03;
  localparam logic [7:0] RST_BASE_LO = 8'hf8;
  localparam logic [7:0] RST_IRQ_SEL = 8'h04;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_ONES = 8'hff;
  localparam logic [7:0] MASK_ACTIVATE = 8'h01;
  localparam logic [7:0] MASK_IRQ_SEL = 8'h0f;
  localparam logic [7:0] MASK_OPTIONS = 8'he3;
  localparam logic [7:0] MASK_NB_IRQ_CTL = 8'h03;
  localparam logic [7:0] MASK_NB_IRQ_STS = 8'h01;
  localparam logic [15:0] BASE_MIN = 16'h0100;
  localparam logic [15:0] BASE_MAX = 16'h0ff8;
  localparam int BASE_ALIGN_BITS = 3;
  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int OPT_PULSE_IRQ = 6;
  localparam int OPT_NEW_ERR = 5;
  localparam int NB_FILTER_ON = 7;
  localparam int NB_COMPARE_ONLY = 6;
  localparam int NB_LONG_HOLD = 5;
  localparam int NB_DIR_INVERT = 4;
  localparam int NB_AUTO_TX_CLR = 3;
  localparam int NB_STORE_ADDR = 2;
  localparam int NB_MULTIDROP = 1;
  localparam int NB_ON = 0;
  localparam int IRQC_TYPE_MATCHED = 1;
  localparam int IRQC_ENABLE = 0;
  // baud divisors as increment over modulus of 24 mhz ticks: 13, 12, 1, 13/8
  localparam logic [3:0] DIV13_INC = 4'h1;
  localparam logic [3:0] DIV13_MOD = 4'hd;
  localparam logic [3:0] DIV12_INC = 4'h1;
  localparam logic [3:0] DIV12_MOD = 4'hc;
  localparam logic [3:0] DIV1_INC = 4'h1;
  localparam logic [3:0] DIV1_MOD = 4'h1;
  localparam logic [3:0] DIVFRAC_INC = 4'h8;
  localparam logic [3:0] DIVFRAC_MOD = 4'hd;
  localparam logic [1:0] HOLD_SHORT = 2'h1;
  localparam logic [1:0] HOLD_LONG = 2'h2;
  // ----------------------------------------------------------------
  // carrier types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic is_addr;
    logic [7:0] data;
  } rx_byte_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] index;
    logic [7:0] wdata;
  } cfg_req_t;
  typedef enum logic [1:0] {
    DIR_RECV = 2'b00,
    DIR_XMIT = 2'b01,
    DIR_HOLD = 2'b11
  } dir_state_t;
endpackage : nine_bit_cfg_pkg

// ### design/serial_port_a_config_nine_bit.sv
// configuration registers and nine bit multidrop logic of the first serial port
`timescale 1ns/1ps
module serial_port_a_config_nine_bit #(
  parameter int IRQ_CHANNELS = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic ld_selected,
  input wire nine_bit_cfg_pkg::cfg_req_t cfg_req,
  output logic [7:0] cfg_rdata,
  input wire logic [15:0] io_addr,
  input wire logic io_cycle,
  output logic io_hit,
  input wire logic uart_irq_req,
  output logic [IRQ_CHANNELS-1:0] irq_lines,
  input wire logic err_orig,
  input wire logic err_new,
  output logic line_status_err,
  input wire logic ref_tick,
  output logic baud_tick,
  input wire nine_bit_cfg_pkg::rx_byte_t rx_in,
  input wire logic rx_in_valid,
  output logic rx_in_ready,
  output nine_bit_cfg_pkg::rx_byte_t rx_out,
  output logic rx_out_valid,
  input wire logic rx_out_ready,
  input wire logic bit_tick,
  input wire logic tx_busy,
  input wire logic tx_addr_sent,
  input wire logic rts_manual,
  output logic addr_byte_clear,
  output logic parity_as_addr,
  output logic rts_out
);
  import nine_bit_cfg_pkg::*;

  // channel select is four bits wide and channel zero means none
  if (IRQ_CHANNELS < 2 || IRQ_CHANNELS > 16) begin : g_bad_channels
    $error("IRQ_CHANNELS must lie between 2 and 16");
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic addr_match(input logic [7:0] b, input logic [7:0] slave,
                                      input logic [7:0] mask, input logic [7:0] bcast);
    addr_match = (((b ^ slave) & mask) == 8'h00) || (b == bcast);
  endfunction : addr_match

  function automatic logic hit(input cfg_req_t r, input logic [7:0] idx);
    hit = r.wr && (r.index == idx);
  endfunction : hit

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  logic [7:0] activate_r;
  logic [7:0] base_hi_r;
  logic [7:0] base_lo_r;
  logic [7:0] irq_sel_r;
  logic [7:0] options_r;
  logic [7:0] nb_cfg_r;
  logic [7:0] slave_r;
  logic [7:0] mask_r;
  logic [7:0] bcast_r;
  logic [7:0] irq_ctl_r;
  logic nb_status_r;
  logic nb_irq_set;
  logic wr_ok;

  // writes are honoured only while the host has this logical device selected
  assign wr_ok = ld_selected && ce;

  always_ff @(posedge clock) begin
    if (srst) begin
      activate_r <= RST_ACTIVATE;
      base_hi_r <= RST_BASE_HI;
      base_lo_r <= RST_BASE_LO;
      irq_sel_r <= RST_IRQ_SEL;
      options_r <= RST_ZERO;
      nb_cfg_r <= RST_ZERO;
      slave_r <= RST_ZERO;
      mask_r <= RST_ONES;
      bcast_r <= RST_ONES;
      irq_ctl_r <= RST_ZERO;
    end else if (wr_ok) begin
      if (hit(cfg_req, ADDR_ACTIVATE)) activate_r <= cfg_req.wdata & MASK_ACTIVATE;
      if (hit(cfg_req, ADDR_BASE_HI)) base_hi_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_BASE_LO)) base_lo_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_IRQ_SEL)) irq_sel_r <= cfg_req.wdata & MASK_IRQ_SEL;
      if (hit(cfg_req, ADDR_OPTIONS)) options_r <= cfg_req.wdata & MASK_OPTIONS;
      if (hit(cfg_req, ADDR_NB_CFG)) nb_cfg_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_SLAVE)) slave_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_MASK)) mask_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_BCAST)) bcast_r <= cfg_req.wdata;
      if (hit(cfg_req, ADDR_NB_IRQ_CTL)) irq_ctl_r <= cfg_req.wdata & MASK_NB_IRQ_CTL;
    end
  end

  // status: hardware set wins over a software write of zero in the same cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      nb_status_r <= 1'b0;
    end else if (ce) begin
      if (nb_irq_set) begin
        nb_status_r <= 1'b1;
      end else if (wr_ok && hit(cfg_req, ADDR_NB_IRQ_STS)) begin
        nb_status_r <= cfg_req.wdata[0];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cfg_rdata <= RST_ZERO;
    end else if (ce) begin
      cfg_rdata <= RST_ZERO;
      if (cfg_req.rd && ld_selected) begin
        unique case (cfg_req.index)
          ADDR_ACTIVATE: cfg_rdata <= activate_r;
          ADDR_BASE_HI: cfg_rdata <= base_hi_r;
          ADDR_BASE_LO: cfg_rdata <= base_lo_r;
          ADDR_IRQ_SEL: cfg_rdata <= irq_sel_r;
          ADDR_OPTIONS: cfg_rdata <= options_r;
          ADDR_NB_CFG: cfg_rdata <= nb_cfg_r;
          ADDR_SLAVE: cfg_rdata <= slave_r;
          ADDR_MASK: cfg_rdata <= mask_r;
          ADDR_BCAST: cfg_rdata <= bcast_r;
          ADDR_NB_IRQ_CTL: cfg_rdata <= irq_ctl_r;
          ADDR_NB_IRQ_STS: cfg_rdata <= {7'h00, nb_status_r};
          default: cfg_rdata <= RST_ZERO;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // io base decode
  // ----------------------------------------------------------------
  logic [15:0] base;
  logic base_ok;
  logic port_on;

  assign base = {base_hi_r, base_lo_r};
  assign base_ok = (base >= BASE_MIN) && (base <= BASE_MAX);
  assign port_on = activate_r[0];

  always_ff @(posedge clock) begin
    if (srst) begin
      io_hit <= 1'b0;
    end else if (ce) begin
      // an out-of-range base decodes nothing rather than aliasing low io space
      io_hit <= io_cycle && port_on && base_ok &&
                (io_addr[15:BASE_ALIGN_BITS] == base[15:BASE_ALIGN_BITS]);
    end
  end

  // ----------------------------------------------------------------
  // interrupt routing and error select
  // ----------------------------------------------------------------
  logic irq_src;
  logic irq_src_d_r;
  logic nb_irq_r;

  assign irq_src = port_on && (uart_irq_req || nb_irq_r);

  always_ff @(posedge clock) begin
    if (srst) begin
      irq_src_d_r <= 1'b0;
      irq_lines <= '0;
      line_status_err <= 1'b0;
    end else if (ce) begin
      irq_src_d_r <= irq_src;
      line_status_err <= options_r[OPT_NEW_ERR] ? err_new : err_orig;
      for (int i = 0; i < IRQ_CHANNELS; i++) begin
        // channel zero means no irq routed
        irq_lines[i] <= (i != 0) && (irq_sel_r[3:0] == 4'(i)) &&
                        (options_r[OPT_PULSE_IRQ] ? (irq_src && !irq_src_d_r) : irq_src);
      end
    end
  end

  // ----------------------------------------------------------------
  // baud clock enable from the 24 mhz tick
  // ----------------------------------------------------------------
  logic [3:0] acc_r;
  logic [3:0] div_inc;
  logic [3:0] div_mod;
  logic [4:0] acc_sum;

  always_comb begin
    unique case (options_r[1:0])
      2'b00: begin
        div_inc = DIV13_INC;
        div_mod = DIV13_MOD;
      end
      2'b01: begin
        div_inc = DIV12_INC;
        div_mod = DIV12_MOD;
      end
      2'b10: begin
        div_inc = DIV1_INC;
        div_mod = DIV1_MOD;
      end
      2'b11: begin
        div_inc = DIVFRAC_INC;
        div_mod = DIVFRAC_MOD;
      end
    endcase
  end

  assign acc_sum = {1'b0, acc_r} + {1'b0, div_inc};

  // the 1.625 divisor yields an average rate; single periods jitter by one tick
  always_ff @(posedge clock) begin
    if (srst) begin
      acc_r <= 4'h0;
      baud_tick <= 1'b0;
    end else if (ce) begin
      baud_tick <= 1'b0;
      if (ref_tick) begin
        if (acc_sum >= {1'b0, div_mod}) begin
          acc_r <= 4'(acc_sum - {1'b0, div_mod});
          baud_tick <= 1'b1;
        end else begin
          acc_r <= acc_sum[3:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // receive filter
  // ----------------------------------------------------------------
  logic rx_take;
  logic rx_push;
  logic rx_match;
  logic rx_ctrl_r;
  logic buf_ready_r;

  assign rx_take = rx_in_valid && buf_ready_r;
  assign rx_match = addr_match(rx_in.data, slave_r, mask_r, bcast_r);

  always_comb begin
    rx_push = rx_take;
    if (nb_cfg_r[NB_ON]) begin
      if (rx_in.is_addr) begin
        rx_push = rx_take && nb_cfg_r[NB_STORE_ADDR];
      end else begin
        rx_push = rx_take && (!nb_cfg_r[NB_FILTER_ON] || rx_ctrl_r);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      rx_ctrl_r <= 1'b0;
    end else if (ce) begin
      if (rx_take && rx_in.is_addr && nb_cfg_r[NB_ON] && nb_cfg_r[NB_FILTER_ON] &&
          !nb_cfg_r[NB_COMPARE_ONLY]) begin
        rx_ctrl_r <= rx_match;
      end
    end
  end

  always_comb begin
    nb_irq_set = rx_take && rx_in.is_addr && nb_cfg_r[NB_ON] && irq_ctl_r[IRQC_ENABLE] &&
                 (!irq_ctl_r[IRQC_TYPE_MATCHED] || rx_match);
    // with filtering on, a non-matching address raises nothing
    if (nb_cfg_r[NB_FILTER_ON] && !rx_match) begin
      nb_irq_set = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      nb_irq_r <= 1'b0;
    end else if (ce) begin
      nb_irq_r <= nb_irq_set;
    end
  end

  // ----------------------------------------------------------------
  // two-entry receive buffer
  // ----------------------------------------------------------------
  rx_byte_t mem_r [2];
  logic wr_ptr_r;
  logic rd_ptr_r;
  logic [1:0] count_r;
  logic [1:0] count_nxt;
  logic pop;

  assign pop = rx_out_valid && rx_out_ready;
  assign rx_in_ready = buf_ready_r;
  assign rx_out = mem_r[rd_ptr_r];

  always_comb begin
    count_nxt = count_r;
    if (rx_push && !pop) count_nxt = 2'(count_r + 2'd1);
    if (pop && !rx_push) count_nxt = 2'(count_r - 2'd1);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wr_ptr_r <= 1'b0;
      rd_ptr_r <= 1'b0;
      count_r <= 2'd0;
      rx_out_valid <= 1'b0;
      buf_ready_r <= 1'b1;
      mem_r[0] <= '0;
      mem_r[1] <= '0;
    end else if (ce) begin
      if (rx_push) begin
        mem_r[wr_ptr_r] <= rx_in;
        wr_ptr_r <= !wr_ptr_r;
      end
      if (pop) rd_ptr_r <= !rd_ptr_r;
      count_r <= count_nxt;
      rx_out_valid <= (count_nxt != 2'd0);
      buf_ready_r <= (count_nxt != 2'd2);
    end
  end

  // ----------------------------------------------------------------
  // transmit side: address enable clear and direction control
  // ----------------------------------------------------------------
  dir_state_t dir_r;
  logic [1:0] hold_r;
  logic driving;

  always_ff @(posedge clock) begin
    if (srst) begin
      addr_byte_clear <= 1'b0;
      parity_as_addr <= 1'b0;
    end else if (ce) begin
      parity_as_addr <= nb_cfg_r[NB_ON];
      addr_byte_clear <= tx_addr_sent && nb_cfg_r[NB_ON] && nb_cfg_r[NB_AUTO_TX_CLR];
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dir_r <= DIR_RECV;
      hold_r <= 2'd0;
    end else if (ce) begin
      unique case (dir_r)
        DIR_RECV: begin
          if (tx_busy) dir_r <= DIR_XMIT;
        end
        DIR_XMIT: begin
          if (!tx_busy) begin
            dir_r <= DIR_HOLD;
            hold_r <= nb_cfg_r[NB_LONG_HOLD] ? HOLD_LONG : HOLD_SHORT;
          end
        end
        DIR_HOLD: begin
          if (tx_busy) begin
            dir_r <= DIR_XMIT;
          end else if (bit_tick) begin
            if (hold_r == 2'd1) dir_r <= DIR_RECV;
            hold_r <= 2'(hold_r - 2'd1);
          end
        end
        default: dir_r <= DIR_RECV;
      endcase
    end
  end

  assign driving = (dir_r != DIR_RECV);

  always_ff @(posedge clock) begin
    if (srst) begin
      rts_out <= 1'b1;
    end else if (ce) begin
      if (nb_cfg_r[NB_MULTIDROP]) begin
        rts_out <= !driving ^ nb_cfg_r[NB_DIR_INVERT];
      end else begin
        rts_out <= rts_manual;
      end
    end
  end
endmodule : serial_port_a_config_nine_bit

// ### verification/serial_port_a_config_nine_bit_monitor.sv
// assertion checker for the serial port configuration block
`timescale 1ns/1ps
module serial_port_a_config_nine_bit_monitor
  import nine_bit_cfg_pkg::*;
#(
  parameter int IRQ_CHANNELS = 16
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic ce,
  input wire logic ld_selected,
  input wire cfg_req_t cfg_req,
  input wire logic [7:0] cfg_rdata,
  input wire logic [15:0] io_addr,
  input wire logic io_cycle,
  input wire logic io_hit,
  input wire logic [IRQ_CHANNELS-1:0] irq_lines,
  input wire logic err_orig,
  input wire logic err_new,
  input wire logic line_status_err,
  input wire logic ref_tick,
  input wire logic baud_tick,
  input wire rx_byte_t rx_out,
  input wire logic rx_out_valid,
  input wire logic rx_out_ready,
  input wire logic bit_tick,
  input wire logic tx_busy,
  input wire logic tx_addr_sent,
  input wire logic addr_byte_clear,
  input wire logic parity_as_addr,
  input wire logic rts_out
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  // --------------------------------------------
  // shadow of the config bits seen on the bus
  // --------------------------------------------
  logic take;
  logic [7:0] nb_r;
  logic ne_r;
  assign take = ce && ld_selected && cfg_req.wr;
  always_ff @(posedge clock) begin
    if (srst) nb_r <= 8'h00;
    else if (take && cfg_req.index == ADDR_NB_CFG) nb_r <= cfg_req.wdata;
  end
  always_ff @(posedge clock) begin
    if (srst) ne_r <= 1'b0;
    else if (take && cfg_req.index == ADDR_OPTIONS) ne_r <= cfg_req.wdata[OPT_NEW_ERR];
  end
  // --------------------------------------------
  // properties
  // --------------------------------------------
  sequence s_wr_slave;
    take && cfg_req.index == ADDR_SLAVE;
  endsequence
  sequence s_rd_slave;
    ce && ld_selected && cfg_req.rd && !cfg_req.wr && cfg_req.index == ADDR_SLAVE;
  endsequence
  a_idle_read_zero: assert property (
    ce && !(ld_selected && cfg_req.rd) |=> cfg_rdata == 8'h00) else $error("stray read data");
  a_slave_readback: assert property (
    s_wr_slave ##1 !take ##1 s_rd_slave |=> cfg_rdata == $past(cfg_req.wdata, 3))
    else $error("slave address readback wrong");
  a_io_range: assert property (
    io_hit && $past(ce) |-> $past(io_cycle) && $past(io_addr) >= BASE_MIN
      && $past(io_addr) <= 16'h0fff) else $error("io hit outside range");
  a_irq_one_line: assert property (
    !irq_lines[0] && $onehot0(irq_lines)) else $error("irq on several lines");
  a_baud_cause: assert property (
    baud_tick |-> $past(ref_tick) && $past(ce)) else $error("baud tick without ref tick");
  a_err_source: assert property (
    ce |=> line_status_err == ($past(ne_r) ? $past(err_new) : $past(err_orig)))
    else $error("wrong error source");
  a_out_hold: assert property (
    rx_out_valid && !rx_out_ready && ce |=> rx_out_valid && $stable(rx_out))
    else $error("buffer head lost while stalled");
  a_clear_cause: assert property (
    addr_byte_clear |-> $past(tx_addr_sent) && $past(nb_r[NB_AUTO_TX_CLR])
      && $past(nb_r[NB_ON])) else $error("address enable cleared without cause");
  a_parity_copy: assert property (
    $stable(nb_r) [*2] |-> parity_as_addr == nb_r[NB_ON]) else $error("nine bit flag wrong");
  a_drive_level: assert property (
    (ce && tx_busy && nb_r[NB_MULTIDROP] && $stable(nb_r)) [*3]
      |-> rts_out == nb_r[NB_DIR_INVERT]) else $error("direction wrong while sending");
  a_recv_level: assert property (
    (ce && !tx_busy && nb_r[NB_MULTIDROP] && $stable(nb_r)) [*8]
      |-> rts_out == !nb_r[NB_DIR_INVERT]) else $error("direction wrong while idle");
  // two edges after the end of a send the output still reflects the hold state
  sequence s_busy_end;
    $fell(tx_busy) && $past(tx_busy, 2) && ce && nb_r[NB_MULTIDROP] && $stable(nb_r);
  endsequence
  a_hold_drive: assert property (
    s_busy_end ##1 $stable(nb_r) ##1 $stable(nb_r) |-> rts_out == nb_r[NB_DIR_INVERT])
    else $error("direction dropped early");
endmodule : serial_port_a_config_nine_bit_monitor

bind serial_port_a_config_nine_bit serial_port_a_config_nine_bit_monitor #(
  .IRQ_CHANNELS(IRQ_CHANNELS)
) u_mon (
  .clock(clock), .srst(srst), .ce(ce), .ld_selected(ld_selected), .cfg_req(cfg_req),
  .cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_cycle(io_cycle), .io_hit(io_hit),
  .irq_lines(irq_lines), .err_orig(err_orig), .err_new(err_new),
  .line_status_err(line_status_err), .ref_tick(ref_tick), .baud_tick(baud_tick),
  .rx_out(rx_out), .rx_out_valid(rx_out_valid), .rx_out_ready(rx_out_ready),
  .bit_tick(bit_tick), .tx_busy(tx_busy), .tx_addr_sent(tx_addr_sent),
  .addr_byte_clear(addr_byte_clear), .parity_as_addr(parity_as_addr), .rts_out(rts_out)
);

// ### verification/far_node.sv
// far serial node: offers received bytes and drains the buffer with stalls
`timescale 1ns/1ps
module far_node
  import nine_bit_cfg_pkg::*;
(
  input wire logic clock,
  input wire logic stall,
  input wire logic rx_in_ready,
  output rx_byte_t rx_in,
  output logic rx_in_valid,
  output logic rx_out_ready
);
  rx_byte_t tx_q[$];
  logic took;
  initial begin
    rx_in = 9'h0aa;
    rx_in_valid = 1'b0;
    rx_out_ready = 1'b0;
    took = 1'b0;
  end
  always @(posedge clock) took <= rx_in_valid && rx_in_ready;
  // a byte stays offered until taken; idle data flips so stale bytes never look valid
  always @(negedge clock) begin
    if (took) void'(tx_q.pop_front());
    if (tx_q.size() > 0) begin
      rx_in <= tx_q[0];
      rx_in_valid <= 1'b1;
    end else begin
      rx_in <= ~rx_in;
      rx_in_valid <= 1'b0;
    end
    rx_out_ready <= !stall && ($urandom % 4 != 0);
  end
endmodule : far_node

// ### verification/serial_port_a_config_nine_bit_tb.sv
// self-checking testbench for the serial port configuration block
`timescale 1ns/1ps
module serial_port_a_config_nine_bit_tb;
  import nine_bit_cfg_pkg::*;
  logic clock, srst, ce, ld_selected, io_cycle, io_hit, uart_irq_req, err_orig, err_new;
  logic line_status_err, ref_tick, baud_tick, rx_in_valid, rx_in_ready, rx_out_valid;
  logic rx_out_ready, bit_tick, tx_busy, tx_addr_sent, rts_manual, addr_byte_clear;
  logic parity_as_addr, rts_out, stall, rctl;
  logic [7:0] cfg_rdata, cfg, slv, msk, bc;
  logic [15:0] io_addr, irq_lines;
  cfg_req_t cfg_req;
  rx_byte_t rx_in, rx_out;
  rx_byte_t q[$];
  int n_mismatch = 0;
  int checked = 0;
  logic [7:0] ra [9] = '{8'h30, 8'h60, 8'h61, 8'h70, 8'hf0, 8'hf2, 8'hf3, 8'hf4, 8'hf5};
  logic [7:0] rv [9] = '{8'h01, 8'h03, 8'hf8, 8'h04, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
  logic [7:0] rm [9] = '{8'h01, 8'hff, 8'hff, 8'h0f, 8'he3, 8'hff, 8'hff, 8'hff, 8'hff};
  logic [7:0] ad [4] = '{8'h33, 8'h53, 8'h71, 8'hc3};
  logic [7:0] cf [5] = '{8'h85, 8'hc5, 8'h81, 8'h01, 8'h00};
  // baud divisor per clock select as a ratio: 13, 12, 1 and 13/8
  int dm [4] = '{13, 12, 1, 13};
  int di [4] = '{1, 1, 1, 8};

  serial_port_a_config_nine_bit u_serial_port_a_config_nine_bit (
    .clock(clock), .srst(srst), .ce(ce), .ld_selected(ld_selected), .cfg_req(cfg_req),
    .cfg_rdata(cfg_rdata), .io_addr(io_addr), .io_cycle(io_cycle), .io_hit(io_hit),
    .uart_irq_req(uart_irq_req), .irq_lines(irq_lines), .err_orig(err_orig),
    .err_new(err_new), .line_status_err(line_status_err), .ref_tick(ref_tick),
    .baud_tick(baud_tick), .rx_in(rx_in), .rx_in_valid(rx_in_valid),
    .rx_in_ready(rx_in_ready), .rx_out(rx_out), .rx_out_valid(rx_out_valid),
    .rx_out_ready(rx_out_ready), .bit_tick(bit_tick), .tx_busy(tx_busy),
    .tx_addr_sent(tx_addr_sent), .rts_manual(rts_manual), .addr_byte_clear(addr_byte_clear),
    .parity_as_addr(parity_as_addr), .rts_out(rts_out)
  );
  far_node u_far_node (
    .clock(clock), .stall(stall), .rx_in_ready(rx_in_ready), .rx_in(rx_in),
    .rx_in_valid(rx_in_valid), .rx_out_ready(rx_out_ready)
  );
  // --------------------------------------------
  // tasks
  // --------------------------------------------
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
    checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic finish_test();
    if (n_mismatch == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    cfg_req <= {1'b1, 1'b0, i, d};
    @(negedge clock);
    cfg_req <= '0;
    @(negedge clock);
  endtask : wr
  task automatic rd(input logic [7:0] i, input logic [7:0] e);
    cfg_req <= {1'b0, 1'b1, i, 8'h00};
    @(negedge clock);
    cfg_req <= '0;
    chk("cfg_rdata", 16'(e), 16'(cfg_rdata));
    @(negedge clock);
  endtask : rd
  task automatic io(input logic [15:0] a, input logic e);
    io_addr <= a;
    @(negedge clock);
    chk("io_hit", 16'(e), 16'(io_hit));
  endtask : io
  // the model filters exactly as the buffer should; bytes are queued in send order
  task automatic send(input logic a, input logic [7:0] d);
    logic m;
    m = (((d ^ slv) & msk) == 8'h00) || (d == bc);
    if (a && cfg[0] && cfg[7] && !cfg[6]) rctl = m;
    if (!cfg[0] || (a ? cfg[2] : (!cfg[7] || rctl))) q.push_back({a, d});
    u_far_node.tx_q.push_back({a, d});
  endtask : send
  // --------------------------------------------
  // clock, free inputs, sink, watchdog
  // --------------------------------------------
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(negedge clock) begin
    bit_tick <= ~bit_tick;
    ref_tick <= 1'($urandom);
  end
  always @(posedge clock) begin
    if (!srst && rx_out_valid && rx_out_ready) begin
      if (q.size() == 0) chk("rx_extra", 16'h0000, 16'h0001);
      else chk("rx_out", 16'(q.pop_front()), 16'(rx_out));
    end
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  // --------------------------------------------
  // main sequence
  // --------------------------------------------
  initial begin
    logic [7:0] d;
    logic kb;
    int n, r;
    void'($urandom(91));
    {srst, ce, ld_selected, io_cycle, uart_irq_req, err_orig, err_new} = 7'b1111000;
    {bit_tick, ref_tick, tx_busy, tx_addr_sent, rts_manual, stall, rctl} = 7'b0;
    cfg_req = '0;
    io_addr = 16'h0000;
    cfg = 8'h00;
    repeat (16) @(negedge clock);
    srst <= 1'b0;
    foreach (ra[k]) rd(ra[k], rv[k]);
    rd(8'h40, 8'h00);
    foreach (ra[k]) begin
      d = 8'($urandom);
      wr(ra[k], d);
      rd(ra[k], d & rm[k]);
    end
    slv = 8'h5a;
    wr(8'hf3, slv);
    ld_selected <= 1'b0;
    wr(8'hf3, 8'h77);
    rd(8'hf3, 8'h00);
    ld_selected <= 1'b1;
    rd(8'hf3, slv);
    wr(8'h30, 8'h01);
    wr(8'h60, 8'h02);
    wr(8'h61, 8'he8);
    for (int i = 0; i < 4; i++) io(16'h02e8 + 16'(i * 4), i < 2);
    io_cycle <= 1'b0;
    io(16'h02e8, 1'b0);
    io_cycle <= 1'b1;
    wr(8'h30, 8'h00);
    io(16'h02e8, 1'b0);
    wr(8'h30, 8'h01);
    wr(8'h60, 8'h00);
    io(16'h00e8, 1'b0);
    wr(8'h70, 8'h05);
    wr(8'hf0, 8'h40);
    uart_irq_req <= 1'b1;
    n = 0;
    repeat (6) begin
      @(negedge clock);
      n += int'(irq_lines != 16'h0000);
    end
    chk("irq_pulses", 16'h0001, 16'(n));
    wr(8'hf0, 8'h00);
    repeat (3) @(negedge clock);
    chk("irq_lines", 16'h0020, irq_lines);
    uart_irq_req <= 1'b0;
    msk = 8'hf0;
    bc = 8'hc3;
    wr(8'hf4, msk);
    wr(8'hf5, bc);
    wr(8'hf6, 8'h03);
    foreach (cf[k]) begin
      cfg = cf[k];
      wr(8'hf2, cfg);
      stall <= 1'b1;
      for (int j = 0; j < 8; j++) send(!j[0], j[0] ? 8'($urandom) : ad[j / 2]);
      repeat (20) @(negedge clock);
      chk("rx_in_ready", 16'h0000, 16'(rx_in_ready));
      stall <= 1'b0;
      for (int t = 0; t < 100 && q.size() > 0; t++) @(negedge clock);
      chk("rx_left", 16'h0000, 16'(q.size()));
    end
    rd(8'hf7, 8'h01);
    cfg = 8'h01;
    wr(8'hf2, cfg);
    wr(8'hf7, 8'h00);
    send(1'b1, ad[0]);
    repeat (4) @(negedge clock);
    rd(8'hf7, 8'h00);
    send(1'b1, ad[1]);
    repeat (4) @(negedge clock);
    rd(8'hf7, 8'h01);
    for (int k = 0; k < 2; k++) begin
      kb = k[0];
      wr(8'hf0, kb ? 8'h20 : 8'h00);
      err_new <= 1'b1;
      err_orig <= 1'b0;
      repeat (2) @(negedge clock);
      chk("line_status_err", 16'(kb), 16'(line_status_err));
      wr(8'hf2, kb ? 8'h3b : 8'h03);
      tx_addr_sent <= 1'b1;
      @(negedge clock);
      tx_addr_sent <= 1'b0;
      chk("addr_byte_clear", 16'(kb), 16'(addr_byte_clear));
      chk("parity_as_addr", 16'h0001, 16'(parity_as_addr));
      tx_busy <= 1'b1;
      repeat (4) @(negedge clock);
      chk("rts_busy", 16'(kb), 16'(rts_out));
      tx_busy <= 1'b0;
      repeat (10) @(negedge clock);
      chk("rts_idle", 16'(!kb), 16'(rts_out));
      wr(8'hf2, 8'h00);
      rts_manual <= kb;
      repeat (2) @(negedge clock);
      chk("rts_manual", 16'(kb), 16'(rts_out));
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'hf0, 8'(m));
      n = 0;
      r = 0;
      repeat (600) begin
        @(negedge clock);
        n += int'(baud_tick);
        r += int'(ref_tick);
      end
      // the accumulator may carry up to twelve ticks at either end of the window
      n = int'(n * dm[m] <= r * di[m] + 12 && r * di[m] <= n * dm[m] + 12);
      chk("baud_ticks", 16'h0001, 16'(n));
    end
    finish_test();
  end
endmodule : serial_port_a_config_nine_bit_tb
